/* File: tb/ipb_source_core.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Interrupt sources and core acceptance model
// ****************
module ipb_source_core (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [24:0] raise_in,
   input wire logic [1:0] core_mask_in,
   input wire ipb_pkg::ipb_arb_t [24:0] arb_in,
   output logic [24:0] pending_out,
   output logic [24:0] accept_out
);
   // Sources change only on the clock or at reset, like the on-chip peripherals they stand for.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pending_out <= 25'h000_0000;
      end else begin
         pending_out <= raise_in;
      end
   end
   // The core takes a level only at or above its mask, so mask 3 admits level 3 alone.
   always_comb begin
      for (int k = 0; k < 25; k++) begin
         accept_out[k] = arb_in[k].req && (arb_in[k].level >= core_mask_in);
      end
   end
endmodule
`default_nettype wire

/* File: tb/irq_priority_level_bank_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module irq_priority_level_bank_tb;
   // ****************
   // Stimulus and wiring
   // ****************
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] w;
      logic [31:0] e;
      logic [1:0] r;
   } ipb_row_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hf;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [24:0] raise = 25'h000_0000;
   logic [1:0] cmask = 2'h2;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [24:0] pend, acc;
   ipb_pkg::ipb_arb_t [24:0] arb;
   int fail_count = 0;
   int checks_done = 0;
   // Low bit of each source field, in source order.
   localparam logic [3:0] LSB [0:24] = '{4'hc, 4'ha, 4'h4, 4'h2, 4'h0, 4'he, 4'hc, 4'ha,
      4'h8, 4'h6, 4'h2, 4'h0, 4'he, 4'hc, 4'ha, 4'h8, 4'h6, 4'h4, 4'h2, 4'he, 4'hc, 4'ha,
      4'h4, 4'h2, 4'h0};
   // Register rows: all-ones writes must read back only the writable bits.
   ipb_row_t rows [0:9] = '{
      '{8'h00, 32'hffff_ffff, 32'h0000_3c00, 2'h0}, // Breakpoint word
      '{8'h04, 32'hffff_ffff, 32'h0000_003f, 2'h0}, // Debug word
      '{8'h08, 32'hffff_ffff, 32'h0000_ffcf, 2'h0}, // Flash word
      '{8'h0c, 32'hffff_ffff, 32'h0000_fffc, 2'h0}, // Port word
      '{8'h10, 32'hffff_ffff, 32'h0000_fc3f, 2'h0}, // Serial word
      '{8'h80, 32'hffff_ffff, 32'h0000_0000, 2'h0},
      '{8'h84, 32'hffff_ffff, 32'h01ff_ffff, 2'h0},
      '{8'h84, 32'h0000_0000, 32'h0000_0000, 2'h0},
      '{8'h14, 32'hffff_ffff, 32'h0000_0000, 2'h2},
      '{8'hfc, 32'h0000_1234, 32'h0000_0000, 2'h2}};
   ipb_priority_bank dut (.MCLK_IN(mclk), .RESET_IN(rst), .AXI_AWADDR_IN(awaddr),
      .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata),
      .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wready),
      .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
      .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arready),
      .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
      .AXI_RREADY_IN(rready), .SRC_PENDING_IN(pend), .ARB_OUT(arb), .IRQ_OUT(irq));
   ipb_source_core partner (.clk_in(mclk), .rst_in(rst), .raise_in(raise),
      .core_mask_in(cmask), .arb_in(arb), .pending_out(pend), .accept_out(acc));
   // Free-running 100 MHz clock.
   always #5 mclk = ~mclk;
   // ****************
   // Bus and compare tasks
   // ****************
   task automatic chk(input logic [74:0] got, input logic [74:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // Each bus task starts one edge late so no signal is driven twice in a time step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
         input string m);
      @(posedge mclk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arv <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, e, m);
      chk(rresp, er, m);
   endtask
   function automatic logic [7:0] waddr(input int k);
      return (k < 2) ? 8'h00 : (k < 5) ? 8'h04 : (k < 12) ? 8'h08 : (k < 19) ? 8'h0c : 8'h10;
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   // Main sequence: table rows, then field, interrupt and reset cases.
   initial begin
      logic [1:0] r;
      logic [1:0] lv;
      logic [74:0] exp;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, r);
         chk(r, rows[i].r, "write response"); // Response
         rchk(rows[i].a, rows[i].e, rows[i].r, "read back"); // Masking
      end
      for (int i = 0; i < 5; i++) wr(8'(4 * i), 32'h0000_0000, r);
      $display("register rows done");
      // Every source at every level, with all sources pending.
      raise <= 25'h1ff_ffff;
      for (int k = 0; k < 25; k++) begin
         for (int c = 1; c < 4; c++) begin
            wr(waddr(k), 32'(c) << LSB[k], r);
            repeat (2) @(posedge mclk);
            lv = (k < 5) ? 2'(c) : 2'(c - 1);
            exp = '0;
            exp[3 * k +: 3] = {1'b1, lv};
            chk(arb, exp, "level decode"); // Decode
            chk(acc[k], lv >= 2'h2, "core mask"); // Core gate
            rchk(waddr(k), 32'(c) << LSB[k], 2'h0, "field place"); // Place
         end
         wr(waddr(k), 32'h0000_0000, r);
      end
      $display("field test done");
      // Partial write: only the upper byte lane of the flash word may land.
      wstrb <= 4'h2;
      wr(8'h08, 32'hffff_ffff, r);
      wstrb <= 4'hf;
      rchk(8'h08, 32'h0000_ff00, 2'h0, "upper lane only"); // Lanes
      // Events latched while masked, then unmasked, then cleared by a read.
      chk(irq, 1'b0, "masked irq");
      rchk(8'h80, 32'h01ff_ffff, 2'h0, "all events");
      rchk(8'h80, 32'h0000_0000, 2'h0, "events cleared");
      wr(8'h08, 32'h0000_0001, r);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0, "still masked");
      wr(8'h84, 32'h0000_0800, r);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b1, "unmasked irq");
      rchk(8'h80, 32'h0000_0800, 2'h0, "one event");
      chk(irq, 1'b0, "irq after clear");
      raise <= 25'h000_0000;
      repeat (3) @(posedge mclk);
      chk(arb, 75'h0, "no pending"); // Pending gate
      $display("interrupt test done");
      // Reset in mid-run with every fifth-word field set and sources pending.
      wr(8'h10, 32'hffff_ffff, r);
      raise <= 25'h1ff_ffff;
      repeat (4) @(posedge mclk);
      chk(irq, 1'b1, "new unmasked event");
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk(arb, 75'h0, "arb after reset"); // Cleared
      for (int i = 0; i < 5; i++) rchk(8'(4 * i), 32'h0000_0000, 2'h0, "reset word");
      $display("reset test done");
      tally_and_finish();
   end
   // Watchdog well beyond the thousand or so cycles the tests need.
   initial begin
      #300000;
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* File: verilog/ipb_pkg.sv */
`default_nettype none
package ipb_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int unsigned SRC_COUNT = 25;
   localparam int unsigned DEBUG_COUNT = 5;
   localparam int unsigned PRIO_COUNT = 5;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned FIELD_W = 2;

   // ****************************************************************
   // Register indices; the byte address is four times the index.
   // ****************************************************************
   localparam logic [5:0] IDX_BREAKPOINT_STEP = 6'h00;
   localparam logic [5:0] IDX_DEBUG_SOURCE = 6'h01;
   localparam logic [5:0] IDX_FLASH_CLOCK_PIN = 6'h02;
   localparam logic [5:0] IDX_PORT_AND_CAN = 6'h03;
   localparam logic [5:0] IDX_SERIAL_AND_PORT = 6'h04;
   localparam logic [5:0] IDX_EVENT_STATUS = 6'h20;
   localparam logic [5:0] IDX_EVENT_MASK = 6'h21;

   // ****************************************************************
   // Writable bits of each priority word and reset values
   // ****************************************************************
   localparam logic [15:0] WMASK [0:4] = '{
      16'h3c00, 16'h003f, 16'hffcf, 16'hfffc, 16'hfc3f};
   localparam logic [15:0] PRIO_RESET = 16'h0000;
   localparam logic [24:0] FLAG_RESET = 25'h000_0000;

   // ****************************************************************
   // Level field codes
   // ****************************************************************
   localparam logic [1:0] CODE_OFF = 2'h0;
   localparam logic [1:0] LEVEL_STEP = 2'h1;
   localparam logic [1:0] LEVEL_IDLE = 2'h0;

   // Where each source's field lives: register index and low bit.
   localparam logic [2:0] FIELD_REG [0:24] = '{
      3'h0, 3'h0, 3'h1, 3'h1, 3'h1,
      3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
      3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3,
      3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
   localparam logic [3:0] FIELD_LSB [0:24] = '{
      4'hc, 4'ha, 4'h4, 4'h2, 4'h0,
      4'he, 4'hc, 4'ha, 4'h8, 4'h6, 4'h2, 4'h0,
      4'he, 4'hc, 4'ha, 4'h8, 4'h6, 4'h4, 4'h2,
      4'he, 4'hc, 4'ha, 4'h4, 4'h2, 4'h0};

   // ****************************************************************
   // Bus answers
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // One forwarded request to the arbitration logic.
   typedef struct packed {
      logic req;
      logic [1:0] level;
   } ipb_arb_t;

endpackage
`default_nettype wire

/* File: verilog/ipb_priority_bank.sv */
// Contract
// - Debug source codes: 00 off, 01 level 1, 10 level 2, 11 level 3.
// - Other source codes: 00 off, 01 level 0, 10 level 1, 11 level 2.
// - Reset clears every level field to the off code.
// - Unimplemented bits read zero and ignore writes.
// - First word: breakpoint0 at 13:12, step counter at 11:10, rest reserved.
// - Second word: receive-full 5:4, transmit-empty 3:2, trace 1:0, rest reserved.
// - Third word: flash buffers-empty 15:14, done 13:12, fault 11:10.
// - Third word: pll slip 9:8, low voltage 7:6, bits 5:4 reserved.
// - Third word: external request B at 3:2, A at 1:0.
// - Fourth word: port D 15:14, port E 13:12, port F 11:10.
// - Fourth word: CAN mailbox 9:8, wake 7:6, fault 5:4, bus-off 3:2.
// - Fifth word: serial0 rx 15:14, serial1 tx 13:12, serial1 rx 11:10.
// - Fifth word: port A at 5:4, port B at 3:2.
// - Fifth word: port C at 1:0, same off-or-level encoding.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ipb_priority_bank (
   input wire logic MCLK_IN,
   input wire logic RESET_IN,
   input wire logic [7:0] AXI_AWADDR_IN,
   input wire logic AXI_AWVALID_IN,
   output logic AXI_AWREADY_OUT,
   input wire logic [31:0] AXI_WDATA_IN,
   input wire logic [3:0] AXI_WSTRB_IN,
   input wire logic AXI_WVALID_IN,
   output logic AXI_WREADY_OUT,
   output logic [1:0] AXI_BRESP_OUT,
   output logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   input wire logic [7:0] AXI_ARADDR_IN,
   input wire logic AXI_ARVALID_IN,
   output logic AXI_ARREADY_OUT,
   output logic [31:0] AXI_RDATA_OUT,
   output logic [1:0] AXI_RRESP_OUT,
   output logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN,
   input wire logic [24:0] SRC_PENDING_IN,
   output ipb_pkg::ipb_arb_t [24:0] ARB_OUT,
   output logic IRQ_OUT
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [15:0] prio [0:4];
   logic [24:0] status;
   logic [24:0] mask;
   logic aw_held;
   logic w_held;
   logic [5:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   ipb_pkg::ipb_arb_t [24:0] arb;

   // Combinational helpers.
   logic wr_go;
   logic [31:0] be;
   logic [15:0] be16;
   logic [5:0] rd_idx;
   logic rd_take;
   logic rd_status;
   logic [31:0] next_rdata;
   logic next_rd_mapped;
   logic wr_mapped;
   logic [1:0] code_of [0:24];
   logic [1:0] next_level [0:24];
   logic [24:0] next_req;
   logic [24:0] req_vec;
   logic [24:0] evt;

   // Byte strobes widened to bit enables.
   function automatic logic [31:0] lanes(input logic [3:0] s);
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // ****************************************************************
   // Write channels
   // ****************************************************************
   // Address and data are held independently so either may come first;
   // both stall while a response waits, which keeps one write in flight.
   assign AXI_AWREADY_OUT = !aw_held && !bvalid;
   assign AXI_WREADY_OUT = !w_held && !bvalid;
   assign wr_go = aw_held && w_held && !bvalid;
   assign be = lanes(w_strb);
   assign be16 = be[15:0];
   assign wr_mapped = (aw_idx < 6'(ipb_pkg::PRIO_COUNT))
      || (aw_idx == ipb_pkg::IDX_EVENT_STATUS)
      || (aw_idx == ipb_pkg::IDX_EVENT_MASK);

   // Capture of the write address.
   always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         aw_held <= 1'b0;
         aw_idx <= 6'h00;
      end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
         aw_held <= 1'b1;
         aw_idx <= AXI_AWADDR_IN[7:2];
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end
   end

   // Capture of the write data and strobes.
   always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         w_held <= 1'b0;
         w_data <= ipb_pkg::READ_ZERO;
         w_strb <= 4'h0;
      end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
         w_held <= 1'b1;
         w_data <= AXI_WDATA_IN;
         w_strb <= AXI_WSTRB_IN;
      end else if (wr_go) begin
         w_held <= 1'b0;
      end
   end

   // Write response; unmapped words answer with a slave error.
   always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         bvalid <= 1'b0;
         bresp <= ipb_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp <= wr_mapped ? ipb_pkg::RESP_OKAY : ipb_pkg::RESP_SLVERR;
      end else if (AXI_BREADY_IN) begin
         bvalid <= 1'b0;
      end
   end

   assign AXI_BVALID_OUT = bvalid;
   assign AXI_BRESP_OUT = bresp;

   // ****************************************************************
   // Priority words
   // ****************************************************************
   // A write lands all enabled lanes in one edge; the fixed mask keeps
   // reserved bits at zero whatever software writes.
   always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         for (int i = 0; i < ipb_pkg::PRIO_COUNT; i++) begin
            prio[i] <= ipb_pkg::PRIO_RESET;
         end
      end else if (wr_go) begin
         for (int i = 0; i < ipb_pkg::PRIO_COUNT; i++) begin
            if (aw_idx == 6'(i)) begin
               prio[i] <= ((prio[i] & ~be16) | (w_data[15:0] & be16))
                  & ipb_pkg::WMASK[i];
            end
         end
      end
   end

   // Interrupt mask word, written lane by lane.
   always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         mask <= ipb_pkg::FLAG_RESET;
      end else if (wr_go && aw_idx == ipb_pkg::IDX_EVENT_MASK) begin
         mask <= (mask & ~be[24:0]) | (w_data[24:0] & be[24:0]);
      end
   end

   // ****************************************************************
   // Level decode and forwarding
   // ****************************************************************
   // Each source picks its field from its word
   for (genvar k = 0; k < ipb_pkg::SRC_COUNT; k++) begin : g_src
      assign code_of[k] =
         prio[ipb_pkg::FIELD_REG[k]][ipb_pkg::FIELD_LSB[k] +: ipb_pkg::FIELD_W];
      assign next_req[k] = SRC_PENDING_IN[k]
         && (code_of[k] != ipb_pkg::CODE_OFF);
      if (k < ipb_pkg::DEBUG_COUNT) begin : g_dbg
         assign next_level[k] = code_of[k];
      end else begin : g_per
         assign next_level[k] = 2'(code_of[k] - ipb_pkg::LEVEL_STEP);
      end
      assign req_vec[k] = arb[k].req;
   end

   // A disabled source shows the idle level so stale levels never leak.
   always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         arb <= '0;
      end else begin
         for (int k = 0; k < ipb_pkg::SRC_COUNT; k++) begin
            arb[k].req <= next_req[k];
            arb[k].level <= next_req[k] ? next_level[k] : ipb_pkg::LEVEL_IDLE;
         end
      end
   end

   assign ARB_OUT = arb;

   // ****************************************************************
   // Event flags and interrupt
   // ****************************************************************
   // An event is a source newly forwarded to arbitration.
   assign evt = next_req & ~req_vec;

   // Reading the status word clears it, but an event in that same
   // cycle sets its flag again so it is never lost.
   always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         status <= ipb_pkg::FLAG_RESET;
      end else begin
         status <= (rd_status ? ipb_pkg::FLAG_RESET : status) | evt;
      end
   end

   assign IRQ_OUT = |(status & mask);

   // ****************************************************************
   // Read channel
   // ****************************************************************
   assign rd_idx = AXI_ARADDR_IN[7:2];
   assign AXI_ARREADY_OUT = !rvalid;
   assign rd_take = AXI_ARVALID_IN && AXI_ARREADY_OUT;
   assign rd_status = rd_take && (rd_idx == ipb_pkg::IDX_EVENT_STATUS);

   // Read data mux; upper bits are zero-filled.
   always_comb begin
      next_rdata = ipb_pkg::READ_ZERO;
      next_rd_mapped = 1'b1;
      if (rd_idx < 6'(ipb_pkg::PRIO_COUNT)) begin
         next_rdata[15:0] = prio[rd_idx[2:0]];
      end else if (rd_idx == ipb_pkg::IDX_EVENT_STATUS) begin
         next_rdata[24:0] = status;
      end else if (rd_idx == ipb_pkg::IDX_EVENT_MASK) begin
         next_rdata[24:0] = mask;
      end else begin
         next_rd_mapped = 1'b0;
      end
   end

   // Read answer registered one edge after the address is taken.
   always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         rvalid <= 1'b0;
         rdata <= ipb_pkg::READ_ZERO;
         rresp <= ipb_pkg::RESP_OKAY;
      end else if (rd_take) begin
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rd_mapped ? ipb_pkg::RESP_OKAY : ipb_pkg::RESP_SLVERR;
      end else if (AXI_RREADY_IN) begin
         rvalid <= 1'b0;
      end
   end

   assign AXI_RVALID_OUT = rvalid;
   assign AXI_RDATA_OUT = rdata;
   assign AXI_RRESP_OUT = rresp;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (RESET_IN);

   // Any set reserved bit across the five words.
   logic rsv_set;
   always_comb begin
      rsv_set = 1'b0;
      for (int i = 0; i < ipb_pkg::PRIO_COUNT; i++) begin
         rsv_set = rsv_set | (|(prio[i] & ~ipb_pkg::WMASK[i]));
      end
   end

   sequence wr_full(logic [5:0] idx);
      wr_go && aw_idx == idx && w_strb == 4'hf;
   endsequence

   sequence rd_of_status;
      rd_status && evt == ipb_pkg::FLAG_RESET;
   endsequence

   sequence unmasked_evt;
      |(evt & mask) && !(wr_go && aw_idx == ipb_pkg::IDX_EVENT_MASK);
   endsequence

   reset_clear_a: assert property (
      $fell(RESET_IN) |-> prio[0] == ipb_pkg::PRIO_RESET
         && prio[2] == ipb_pkg::PRIO_RESET && !ARB_OUT[11].req)
      else $error("priority word not cleared by reset");

   reserved_zero_a: assert property (
      !rsv_set)
      else $error("reserved priority bit became set");

   debug_map_a: assert property (
      SRC_PENDING_IN[0] && code_of[0] != ipb_pkg::CODE_OFF
         |=> ARB_OUT[0].req && ARB_OUT[0].level == $past(code_of[0]))
      else $error("debug source level not mapped one to one");

   periph_map_a: assert property (
      SRC_PENDING_IN[11] && code_of[11] != ipb_pkg::CODE_OFF
         |=> ARB_OUT[11].level == 2'($past(code_of[11]) - ipb_pkg::LEVEL_STEP))
      else $error("peripheral source level not shifted down by one");

   off_blocks_a: assert property (
      code_of[19] == ipb_pkg::CODE_OFF |=> !ARB_OUT[19].req)
      else $error("disabled source forwarded");

   word_write_a: assert property (
      wr_full(ipb_pkg::IDX_FLASH_CLOCK_PIN) |=> AXI_BVALID_OUT
         && prio[2] == ($past(w_data[15:0]) & ipb_pkg::WMASK[2]))
      else $error("priority word not written in one cycle");

   first_word_a: assert property (
      wr_full(ipb_pkg::IDX_BREAKPOINT_STEP) |=>
         code_of[0] == $past(w_data[13:12]) && code_of[1] == $past(w_data[11:10]))
      else $error("breakpoint or step field misplaced");

   fifth_word_a: assert property (
      wr_full(ipb_pkg::IDX_SERIAL_AND_PORT) |=>
         code_of[19] == $past(w_data[15:14]) && code_of[24] == $past(w_data[1:0]))
      else $error("fifth word field misplaced");

   flag_set_a: assert property (
      $rose(ARB_OUT[5].req) |-> status[5] ##1 (status[5] || $past(rd_status)))
      else $error("event flag not set by new request");

   read_clear_a: assert property (
      rd_of_status |=> status == ipb_pkg::FLAG_RESET && AXI_RVALID_OUT)
      else $error("status read did not clear flags");

   irq_raise_a: assert property (
      $rose(ARB_OUT[3].req) && mask[3] |-> IRQ_OUT)
      else $error("unmasked event did not raise interrupt");

   rd_answer_a: assert property (
      rd_take |=> AXI_RVALID_OUT && AXI_RDATA_OUT[31:25] == 7'h00)
      else $error("read answer late or upper bits set");

   // A new request that software has unmasked must reach the interrupt line on
   // the next edge, even when a status read in that cycle clears the other flags.
   irq_event_a: assert property (
      unmasked_evt |=> IRQ_OUT)
      else $error("unmasked event did not reach the interrupt line");

   second_word_a: assert property (
      wr_full(ipb_pkg::IDX_DEBUG_SOURCE) |=>
         code_of[2] == $past(w_data[5:4]) && code_of[4] == $past(w_data[1:0]))
      else $error("second word field misplaced");

   fourth_word_a: assert property (
      wr_full(ipb_pkg::IDX_PORT_AND_CAN) |=>
         code_of[12] == $past(w_data[15:14]) && code_of[18] == $past(w_data[3:2]))
      else $error("fourth word field misplaced");

   // Unmapped words must answer with an error, never with a silent okay.
   write_err_a: assert property (
      wr_go && !wr_mapped |=> AXI_BVALID_OUT && AXI_BRESP_OUT == ipb_pkg::RESP_SLVERR)
      else $error("unmapped write not refused");

   read_err_a: assert property (
      rd_take && !next_rd_mapped |=> AXI_RRESP_OUT == ipb_pkg::RESP_SLVERR
         && AXI_RDATA_OUT == ipb_pkg::READ_ZERO)
      else $error("unmapped read not refused");

   // A source that is not forwarded must show the idle level; a peripheral
   // field of zero would otherwise decode to the top level by wrap-around.
   idle_level_a: assert property (
      !next_req[7] |=> ARB_OUT[7].level == ipb_pkg::LEVEL_IDLE)
      else $error("idle source shows a level");

endmodule
`default_nettype wire
